//--- dv/led_dimming_controller_tb.sv
// self-checking testbench for the led dimming controller
`define CHECK(act, exp) begin tests_run++; if ((act) !== (exp)) begin errors++; \
  $display("MISMATCH %0t value differs", $time); end end
module led_dimming_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock;
  logic        rst = 1'b1;
  logic        enable = 1'b0;
  logic        rate_select_at_regulator = 1'b0;
  logic        run = 1'b0;
  logic        pwm_in;
  logic        direct_chk = 1'b0;
  logic        sd_prev = 1'b0;
  logic        startup_done;
  logic [2:0]  hist = 3'h0;
  logic [5:0]  present = 6'h00;
  logic [5:0]  sink_en;
  logic [5:0]  used;
  logic [7:0]  duty;
  logic [7:0]  duty_prev = 8'h00;
  logic [15:0] high_cyc = 16'h0190;
  logic [15:0] period_cyc = 16'h03E8;
  logic [17:0] dimming_rate = 18'h007D0;
  logic [5:0]  used_q[$];
  logic [7:0]  duty_q[$];
  int          errors = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          on_cnt[6];
  int          rise_at[6];
  int          ch_rank;
  int          ref_ch;
  logic [5:0]  en_prev;

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  led_dimming_controller led_dimming_controller_i (
    .clock(clock), .rst(rst), .enable(enable), .pwm_in(pwm_in),
    .rate_select_at_regulator(rate_select_at_regulator), .dimming_rate(dimming_rate),
    .current_sink_channel_present(present), .current_sink_channel_en(sink_en),
    .channel_used(used), .duty_value(duty), .startup_done(startup_done));

  pwm_host_model pwm_host_model_i (
    .clock(clock), .run(run), .high_cyc(high_cyc), .period_cyc(period_cyc), .pwm(pwm_in));

  // pin history: the sink enables trail the pin by three edges in direct mode
  always @(posedge clock) hist <= {hist[1:0], pwm_in};

  task automatic test_done;
    if (errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  always @(negedge clock) begin
    cycles++;
    if (cycles >= 60000) begin
      errors++;
      test_done();
    end
    if (startup_done === 1'b1 && sd_prev !== 1'b1)
      `CHECK(used, used_q.size() ? used_q.pop_front() : {6{1'bX}})
    if (duty !== duty_prev)
      `CHECK(duty, duty_q.size() ? duty_q.pop_front() : 8'hXX)
    if (direct_chk)
      `CHECK(sink_en, hist[2] ? used : 6'h00)
    sd_prev <= startup_done;
    duty_prev <= duty;
  end

  task automatic wait_startup;
    int n;
    n = 0;
    while (startup_done !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    `CHECK(startup_done, 1'b1)
  endtask : wait_startup

  initial begin
    void'($urandom(78));
    present = 6'($urandom_range(63, 1));
    repeat (16) @(negedge clock);
    rst = 1'b0;
    enable = 1'b1;
    used_q.push_back(present);
    wait_startup();
    repeat (100) begin
      @(negedge clock);
      `CHECK(sink_en, 6'h00)
    end
    duty_q.push_back(8'h66);
    run = 1'b1;
    repeat (8000) @(negedge clock);
    // any window of one dimming period holds 798 to 802 on cycles per present channel and none for absent ones
    foreach (on_cnt[k]) on_cnt[k] = 0;
    foreach (rise_at[k]) rise_at[k] = 0;
    en_prev = sink_en;
    for (int c = 0; c < 2000; c++) begin
      @(negedge clock);
      foreach (on_cnt[k]) begin
        on_cnt[k] += int'(sink_en[k]);
        if (sink_en[k] && !en_prev[k]) rise_at[k] = c;
      end
      en_prev = sink_en;
    end
    foreach (on_cnt[k])
      `CHECK(present[k] ? (on_cnt[k] >= 798 && on_cnt[k] <= 802) : (on_cnt[k] == 0), 1'b1)
    // successive used channels start one period over the used count apart
    ch_rank = 0;
    ref_ch = 0;
    foreach (rise_at[k])
      if (present[k]) begin
        if (ch_rank == 0) ref_ch = k;
        `CHECK((rise_at[k] - rise_at[ref_ch] + 2000) % 2000, ch_rank * (2000 / $countones(present)))
        ch_rank++;
      end
    high_cyc = 16'h018E;
    repeat (6000) @(negedge clock);
    duty_q.push_back(8'h64);
    high_cyc = 16'h0188;
    repeat (6000) @(negedge clock);
    `CHECK(duty_q.size() == 0, 1'b1)
    duty_q.push_back(8'h00);
    enable = 1'b0;
    run = 1'b0;
    repeat (10) @(negedge clock);
    `CHECK({sink_en, used, startup_done}, 13'h0000)
    rate_select_at_regulator = 1'b1;
    high_cyc = 16'h001E;
    period_cyc = 16'h0064;
    used_q.push_back(present);
    enable = 1'b1;
    wait_startup();
    run = 1'b1;
    repeat (300) @(negedge clock);
    direct_chk = 1'b1;
    repeat (1500) @(negedge clock);
    direct_chk = 1'b0;
    `CHECK(duty, 8'h00)
    `CHECK(used_q.size() + duty_q.size() == 0, 1'b1)
    test_done();
  end
endmodule : led_dimming_controller_tb

//--- dv/pwm_host_model.sv
// host model that drives the brightness pwm line with a set high time and period
module pwm_host_model (
  input  wire logic        clock,
  input  wire logic        run,
  input  wire logic [15:0] high_cyc,
  input  wire logic [15:0] period_cyc,
  output logic             pwm
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt;
  logic [15:0] hi;
  logic [15:0] per;
  // settings are taken at a period boundary or while run is low, so a settings change never cuts a pulse short
  always @(negedge clock) begin
    if (!run) begin
      cnt <= 16'h0000;
      pwm <= 1'b0;
      hi  <= high_cyc;
      per <= period_cyc;
    end else begin
      pwm <= (cnt < hi);
      if (cnt == per - 16'h0001) begin
        cnt <= 16'h0000;
        hi  <= high_cyc;
        per <= period_cyc;
      end else begin
        cnt <= cnt + 16'h0001;
      end
    end
  end
endmodule : pwm_host_model

//--- hdl/dimming_pkg.sv
// shared constants for the led dimming controller
package dimming_pkg;
  localparam int          CLOCK_HZ          = 40000000;
  localparam int          CHANNELS          = 6;
  localparam int          DUTY_W            = 8;
  localparam int          PERIOD_W          = 18;
  localparam int          RATE_MIN_HZ       = 210;
  localparam int          RATE_MAX_HZ       = 20000;
  // longest dimming period in cycles, rounded down
  localparam int          PERIOD_MAX_CYC    = CLOCK_HZ / RATE_MIN_HZ;
  // shortest dimming period in cycles, rounded down
  localparam int          PERIOD_MIN_CYC    = CLOCK_HZ / RATE_MAX_HZ;
  localparam logic [17:0] PERIOD_RESET      = 18'h00C35;
  localparam int          MEAS_W            = 20;
  localparam logic [19:0] MEAS_TIMEOUT      = 20'hFFFFF;
  localparam logic [7:0]  DUTY_RESET        = 8'h00;
  localparam logic [7:0]  DUTY_FULL         = 8'hFF;
  localparam int          PROBE_CYC         = 64;
  localparam logic [6:0]  PROBE_RESET       = 7'h00;
endpackage : dimming_pkg

//--- hdl/duty_decoder.sv
// measures input pwm high time and period and yields an 8-bit duty code
module duty_decoder #(
  parameter int MEAS_W = dimming_pkg::MEAS_W
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic        pwm_sync,
  output logic             sample_valid,
  output logic [7:0]       sample_duty,
  output logic             active
);
  logic [MEAS_W-1:0] high_reg;
  logic [MEAS_W-1:0] period_reg;
  logic              prev_reg;
  logic              seen_rise_reg;
  logic              rise;
  logic [MEAS_W+7:0] scaled;

  assign rise   = pwm_sync && !prev_reg;
  // ratio scaled so a full high period maps to the top code
  assign scaled = ({8'h00, high_reg} << 8) - {8'h00, high_reg};

  always_ff @(posedge clock) begin
    if (rst || !run) begin
      high_reg      <= '0;
      period_reg    <= '0;
      prev_reg      <= 1'b0;
      seen_rise_reg <= 1'b0;
      sample_valid  <= 1'b0;
      sample_duty   <= dimming_pkg::DUTY_RESET;
      active        <= 1'b0;
    end else begin
      prev_reg     <= pwm_sync;
      sample_valid <= 1'b0;
      if (rise) begin
        seen_rise_reg <= 1'b1;
        active        <= 1'b1;
        // the rising cycle is already a high cycle
        high_reg      <= {{(MEAS_W-1){1'b0}}, 1'b1};
        period_reg    <= {{(MEAS_W-1){1'b0}}, 1'b1};
        if (seen_rise_reg && period_reg != '0) begin
          sample_valid <= 1'b1;
          sample_duty  <= 8'((scaled + {8'h00, period_reg >> 1}) / {8'h00, period_reg});
        end
      end else if (period_reg == dimming_pkg::MEAS_TIMEOUT) begin
        // steady level: treat as 0% or 100% duty
        sample_valid  <= seen_rise_reg || pwm_sync;
        active        <= active || pwm_sync;
        sample_duty   <= pwm_sync ? dimming_pkg::DUTY_FULL : dimming_pkg::DUTY_RESET;
        period_reg    <= '0;
        high_reg      <= '0;
        seen_rise_reg <= 1'b0;
      end else begin
        period_reg <= period_reg + 1'b1;
        if (pwm_sync)
          high_reg <= high_reg + 1'b1;
      end
    end
  end
endmodule : duty_decoder

//--- hdl/led_dimming_controller.sv
// led dimming controller: duty decode, phase-shift regeneration, direct mode
module led_dimming_controller #(
  parameter int CHANNELS = dimming_pkg::CHANNELS,
  parameter int PERIOD_W = dimming_pkg::PERIOD_W
) (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                enable,
  input  wire logic                pwm_in,
  input  wire logic                rate_select_at_regulator,
  input  wire logic [PERIOD_W-1:0] dimming_rate,
  input  wire logic [CHANNELS-1:0] current_sink_channel_present,
  output logic      [CHANNELS-1:0] current_sink_channel_en,
  output logic      [CHANNELS-1:0] channel_used,
  output logic      [7:0]          duty_value,
  output logic                     startup_done
);
  typedef enum {ST_OFF, ST_PROBE, ST_WAIT, ST_RUN} state_e;

  state_e                state_reg;
  logic [1:0]            en_sync_reg, pwm_sync_reg, mode_sync_reg;
  logic [6:0]            probe_reg;
  logic [7:0]            pending_reg;
  logic [PERIOD_W-1:0]   period_reg;
  logic [PERIOD_W-1:0]   count_reg;
  logic [PERIOD_W-1:0]   slot_reg;
  logic [PERIOD_W-1:0]   on_reg;
  logic                  direct;
  logic                  enabled;
  logic                  dec_valid;
  logic [7:0]            dec_duty;
  logic                  dec_active;
  logic [2:0]            used_count;
  logic [CHANNELS-1:0]   en_next;
  logic [PERIOD_W-1:0]   period_next;

  function automatic logic [2:0] popcount(input logic [CHANNELS-1:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < CHANNELS; i++)
      n = n + {2'h0, v[i]};
    return n;
  endfunction : popcount

  // pins come from outside the clock domain
  always_ff @(posedge clock) begin
    if (rst) begin
      en_sync_reg   <= 2'h0;
      pwm_sync_reg  <= 2'h0;
      mode_sync_reg <= 2'h0;
    end else begin
      en_sync_reg   <= {en_sync_reg[0], enable};
      pwm_sync_reg  <= {pwm_sync_reg[0], pwm_in};
      mode_sync_reg <= {mode_sync_reg[0], rate_select_at_regulator};
    end
  end

  assign enabled    = en_sync_reg[1];
  assign direct     = mode_sync_reg[1];
  assign used_count = popcount(channel_used);

  // decoder only runs in phase-shift mode once enabled
  duty_decoder duty_decoder_i (
    .clock        (clock),
    .rst          (rst),
    .run          (enabled && !direct),
    .pwm_sync     (pwm_sync_reg[1]),
    .sample_valid (dec_valid),
    .sample_duty  (dec_duty),
    .active       (dec_active)
  );

  // startup sequencing
  always_ff @(posedge clock) begin
    if (rst || !enabled) begin
      state_reg    <= ST_OFF;
      probe_reg    <= dimming_pkg::PROBE_RESET;
      channel_used <= '0;
      startup_done <= 1'b0;
    end else begin
      case (state_reg)
        ST_OFF: begin
          state_reg <= ST_PROBE;
        end
        ST_PROBE: begin
          probe_reg <= probe_reg + 7'h01;
          if (probe_reg == 7'(dimming_pkg::PROBE_CYC - 1)) begin
            channel_used <= current_sink_channel_present;
            startup_done <= 1'b1;
            state_reg    <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (direct ? pwm_sync_reg[1] : dec_active)
            state_reg <= ST_RUN;
        end
        ST_RUN: begin
          state_reg <= ST_RUN;
        end
        default: state_reg <= ST_OFF;
      endcase
    end
  end

  // measured duty with hysteresis, then latched at period start
  always_ff @(posedge clock) begin
    if (rst || !enabled) begin
      pending_reg <= dimming_pkg::DUTY_RESET;
    end else if (dec_valid) begin
      if (dec_duty > pending_reg || {1'b0, dec_duty} + 9'h001 < {1'b0, pending_reg}
          || dec_duty == dimming_pkg::DUTY_RESET)
        pending_reg <= dec_duty;
    end
  end

  // clamp to the covered range
  assign period_next = (dimming_rate < PERIOD_W'(dimming_pkg::PERIOD_MIN_CYC))
                       ? PERIOD_W'(dimming_pkg::PERIOD_MIN_CYC)
                       : (dimming_rate > PERIOD_W'(dimming_pkg::PERIOD_MAX_CYC))
                       ? PERIOD_W'(dimming_pkg::PERIOD_MAX_CYC) : dimming_rate;

  // dimming period counter
  always_ff @(posedge clock) begin
    if (rst || state_reg != ST_RUN || direct) begin
      count_reg  <= '0;
      period_reg <= dimming_pkg::PERIOD_RESET;
      duty_value <= dimming_pkg::DUTY_RESET;
      on_reg     <= '0;
      slot_reg   <= '0;
    end else if (count_reg == '0) begin
      count_reg  <= period_next - 1'b1;
      period_reg <= period_next;
      duty_value <= pending_reg;
      // code 255 is full on, so the on-time scales by 255, not 256
      on_reg     <= PERIOD_W'(({10'h000, period_next} * {18'h00000, pending_reg}) / 28'h00000FF);
      slot_reg   <= period_next / PERIOD_W'(used_count == 3'h0 ? 3'h1 : used_count);
    end else begin
      count_reg <= count_reg - 1'b1;
    end
  end

  // per-channel enable; k-th used channel starts k slots into the period
  always_comb begin
    logic [2:0]          rank;
    logic [PERIOD_W-1:0] elapsed;
    logic [PERIOD_W-1:0] start;
    logic [PERIOD_W-1:0] pos;
    rank    = 3'h0;
    start   = '0;
    pos     = '0;
    elapsed = period_reg - 1'b1 - count_reg;
    en_next = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      start = PERIOD_W'(slot_reg * rank);
      pos   = (elapsed >= start) ? elapsed - start : elapsed + period_reg - start;
      if (channel_used[i]) begin
        en_next[i] = (duty_value == dimming_pkg::DUTY_FULL) || (pos < on_reg);
        rank       = rank + 3'h1;
      end
    end
  end

  // no gap at the reload cycle: a pulse that wraps the period end must not be split
  always_ff @(posedge clock) begin
    if (rst || !enabled || state_reg != ST_RUN)
      current_sink_channel_en <= '0;
    else if (direct)
      current_sink_channel_en <= {CHANNELS{pwm_sync_reg[1]}} & channel_used;
    else
      current_sink_channel_en <= en_next;
  end

  sequence off_seq;
    !enabled;
  endsequence
  sequence zero_seq;
    current_sink_channel_en == '0;
  endsequence

  shutdown_idle_a: assert property (@(posedge clock) disable iff (rst)
    off_seq ##1 off_seq |-> ##1 zero_seq) else $error("sinks active while disabled");
  direct_follow_a: assert property (@(posedge clock) disable iff (rst)
    (state_reg == ST_RUN && direct && $stable(direct)) |=>
    current_sink_channel_en == ({CHANNELS{$past(pwm_sync_reg[1])}} & channel_used)
    || !enabled || !direct) else $error("direct mode not following input");
  unused_off_a: assert property (@(posedge clock) disable iff (rst)
    (current_sink_channel_en & ~channel_used) == '0) else $error("unused channel driven");
  wait_idle_a: assert property (@(posedge clock) disable iff (rst)
    state_reg == ST_WAIT |=> zero_seq) else $error("sinks active before activity");
  duty_hold_a: assert property (@(posedge clock) disable iff (rst)
    (state_reg == ST_RUN && count_reg != '0 && !direct) |=> $stable(duty_value) || !enabled)
    else $error("duty changed mid period");
  decode_off_a: assert property (@(posedge clock) disable iff (rst)
    direct ##1 direct |-> !dec_valid) else $error("decoder active in direct mode");
  hyst_fall_a: assert property (@(posedge clock) disable iff (rst)
    (dec_valid && enabled && dec_duty != 8'h00 && {1'b0, dec_duty} + 9'h001 == {1'b0, pending_reg})
    |=> $stable(pending_reg)) else $error("one lsb fall accepted");
  period_range_a: assert property (@(posedge clock) disable iff (rst)
    period_reg >= PERIOD_W'(dimming_pkg::PERIOD_MIN_CYC)
    && period_reg <= PERIOD_W'(dimming_pkg::PERIOD_MAX_CYC)) else $error("period out of range");
  zero_duty_off_a: assert property (@(posedge clock) disable iff (rst)
    (state_reg == ST_RUN && enabled && !direct && duty_value == dimming_pkg::DUTY_RESET)
    |=> zero_seq) else $error("sinks on at zero duty");
  used_fixed_a: assert property (@(posedge clock) disable iff (rst)
    startup_done && $stable(startup_done) |-> $stable(channel_used))
    else $error("channel mask changed");
  decode_idle_a: assert property (@(posedge clock) disable iff (rst)
    direct |=> !dec_active) else $error("decoder still active in direct mode");
endmodule : led_dimming_controller
